// File: design/itt_consts.svh
// Constants of the interval and time-base timer: offsets, fields, resets, counts
//
// Contract
// - Output select: system /32../4, subclock /32../4
// - Mode register bit 4 always reads one
// - Mode bit 3: interval or time base
// - Interval taps: /8192 down to /8
// - Time-base periods: 1, 0.5, 0.25, 0.03125 s
// - Time base, select 1XX: hold prescaler, counter
// - Counter counts ticks; unreadable in subactive
// - Counter resets to zero
// - Wrap at all ones, set overflow flag
// - Interrupt only when overflow enable set
// - After reset count as interval timer
// - Mode and select bit 2 written: clear
// - Clock out only while output enabled
// - System outputs off in subactive mode
// - Subclock synchronised into system clock
`ifndef ITT_CONSTS_SVH
`define ITT_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ITT_ADDR_MODE    3'h0
`define ITT_ADDR_COUNT   3'h1
`define ITT_ADDR_STATUS  3'h2
`define ITT_ADDR_MASK    3'h3
`define ITT_ADDR_CTRL    3'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ITT_MODE_RSVD_BIT  4
`define ITT_OVF_BIT        0
`define ITT_CLKOUT_EN_BIT  0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ITT_MODE_RST    8'h10
`define ITT_COUNT_RST   8'h00
`define ITT_STATUS_RST  8'h00
`define ITT_MASK_RST    8'h00
`define ITT_CTRL_RST    8'h00

// ----------------------------------------------------------------
// Timing: prescaler tap shifts (divide by two to the shift)
// ----------------------------------------------------------------
`define ITT_SUB_HZ      32768
`define ITT_S_TAP0      4'hd
`define ITT_S_TAP1      4'hc
`define ITT_S_TAP2      4'hb
`define ITT_S_TAP3      4'h9
`define ITT_S_TAP4      4'h8
`define ITT_S_TAP5      4'h7
`define ITT_S_TAP6      4'h5
`define ITT_S_TAP7      4'h3
`define ITT_W_TAP0      4'h7
`define ITT_W_TAP1      4'h6
`define ITT_W_TAP2      4'h5
`define ITT_W_TAP3      4'h2

`endif

// File: design/itt_pkg.sv
// Types of the interval and time-base timer
package itt_pkg;

    // Operating power mode of the surrounding chip
    typedef enum logic [1:0] {
        ITT_ACTIVE,
        ITT_SLEEP,
        ITT_SUBACTIVE,
        ITT_STANDBY
    } itt_pmode_t;

    // Layout of the mode register
    typedef struct packed {
        logic [2:0] out_sel;
        logic       rsvd;
        logic       timebase_mode_bit;
        logic [2:0] in_sel;
    } itt_mode_t;

    // One register bus request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } itt_req_t;

endpackage

// File: design/itt_timer.sv
// Interval and time-base timer with divided clock output
`timescale 1ns/1ps
`include "itt_consts.svh"

module itt_timer
    import itt_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int S_W   = 13,
    parameter int W_W   = 8
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Subclock pin, asynchronous to clk
    input  wire logic       sub_clk_in,
    // Power mode from the system controller
    input  wire itt_pmode_t power_mode,
    // Register port
    input  wire itt_req_t   req,
    output logic [7:0]      rdata,
    // Pins and interrupt
    output logic            divided_clock_out,
    output logic            irq
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Taps and the all-ones compare assume these exact widths
    if (CNT_W != 8) begin : g_bad_cnt
        $error("itt_timer: CNT_W must be 8");
    end
    if (S_W != 13) begin : g_bad_s
        $error("itt_timer: S_W must be 13");
    end
    if (W_W != 8) begin : g_bad_w
        $error("itt_timer: W_W must be 8");
    end

    // Every tap must lie inside its prescaler, or no tick ever comes
    if (`ITT_S_TAP0 > S_W) begin : g_bad_s_tap
        $error("itt_timer: interval tap beyond the prescaler");
    end
    if (`ITT_W_TAP0 > W_W) begin : g_bad_w_tap
        $error("itt_timer: time-base tap beyond the prescaler");
    end
    // Clock-out taps read prescaler bits 1 to 4
    if (S_W < 5 || W_W < 5) begin : g_bad_out_tap
        $error("itt_timer: prescalers too narrow for clock out");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // True when the low n bits of v are all ones
    function automatic logic low_ones(input logic [12:0] v,
                                      input logic [3:0]  n);
        logic [12:0] m;
        // Bits at and above n are forced to one
        m = ~(13'h1fff << n);
        return &(v | ~m);
    endfunction

    // Interval tap shift for a select code
    // Shift k gives one tick every two to the k clocks
    function automatic logic [3:0] s_shift(input logic [2:0] sel);
        logic [3:0] r;
        r = `ITT_S_TAP0;
        unique case (sel)
            3'h0: r = `ITT_S_TAP0;
            3'h1: r = `ITT_S_TAP1;
            3'h2: r = `ITT_S_TAP2;
            3'h3: r = `ITT_S_TAP3;
            3'h4: r = `ITT_S_TAP4;
            3'h5: r = `ITT_S_TAP5;
            3'h6: r = `ITT_S_TAP6;
            3'h7: r = `ITT_S_TAP7;
        endcase
        return r;
    endfunction

    // Time-base tap shift for the low two select bits
    // Counted in synchronised subclock rising edges
    function automatic logic [3:0] w_shift(input logic [1:0] sel);
        logic [3:0] r;
        r = `ITT_W_TAP0;
        unique case (sel)
            2'h0: r = `ITT_W_TAP0;
            2'h1: r = `ITT_W_TAP1;
            2'h2: r = `ITT_W_TAP2;
            2'h3: r = `ITT_W_TAP3;
        endcase
        return r;
    endfunction

    // Clock-out tap pick: code 0 is the slowest tap
    function automatic logic out_tap(input logic [3:0] taps,
                                     input logic [1:0] sel);
        logic b;
        b = taps[0];
        unique case (sel)
            2'h0: b = taps[0];
            2'h1: b = taps[1];
            2'h2: b = taps[2];
            2'h3: b = taps[3];
        endcase
        return b;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Software-visible state
    itt_mode_t        mode_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [7:0]       status_r;
    logic [7:0]       status_nxt;
    logic [7:0]       mask_r;
    logic [7:0]       ctrl_r;

    // Read data flop
    logic [7:0]       rdata_r;
    logic [7:0]       rdata_nxt;

    // Prescalers
    logic [S_W-1:0]   s_cnt_r;
    logic [W_W-1:0]   w_cnt_r;
    logic [W_W-1:0]   w_cnt_nxt;

    // Subclock synchroniser chain
    logic             sub_meta_r;
    logic             sub_sync_r;
    logic             sub_prev_r;

    // Clock-out pin flop
    logic             clk_out_r;
    logic             clk_out_nxt;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Each strobe is one cycle, so each decode is too
    wire wr_mode   = req.wr && (req.addr == `ITT_ADDR_MODE);
    wire wr_status = req.wr && (req.addr == `ITT_ADDR_STATUS);
    wire wr_mask   = req.wr && (req.addr == `ITT_ADDR_MASK);
    wire wr_ctrl   = req.wr && (req.addr == `ITT_ADDR_CTRL);
    // Counter offset has no write path at all

    // Write data seen through the mode layout
    itt_mode_t wmode;
    assign wmode = itt_mode_t'(req.wdata);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire tb_mode   = mode_r.timebase_mode_bit;
    wire tb_hold   = tb_mode && mode_r.in_sel[2];
    // Clearing on the write itself avoids one stray tick
    wire wr_clear  = wr_mode && wmode.timebase_mode_bit
                     && wmode.in_sel[2];
    // Standby and sleep are treated like active here
    wire subactive = (power_mode == ITT_SUBACTIVE);
    // Counter and subclock prescaler clear together
    wire clr_cnt   = tb_hold || wr_clear;

    // ------------------------------------------------------------
    // Subclock synchroniser
    // ------------------------------------------------------------
    // Two flops then edge detect; costs up to one clk of jitter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sub_meta_r <= 1'b0;
            sub_sync_r <= 1'b0;
            sub_prev_r <= 1'b0;
        end else begin
            sub_meta_r <= sub_clk_in;
            sub_sync_r <= sub_meta_r;
            sub_prev_r <= sub_sync_r;
        end
    end

    // One clk wide pulse per subclock rise; the third flop
    // only remembers the last level for this compare
    wire w_step = sub_sync_r && !sub_prev_r;

    // ------------------------------------------------------------
    // Prescalers
    // ------------------------------------------------------------
    // System prescaler runs free every clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_cnt_r <= '0;
        end else begin
            s_cnt_r <= s_cnt_r + 1'b1;
        end
    end

    // Subclock prescaler steps on each synchronised edge
    // and is cleared with the counter
    assign w_cnt_nxt = clr_cnt ? '0 :
                       w_step ? w_cnt_r + 1'b1 : w_cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_cnt_r <= '0;
        end else begin
            w_cnt_r <= w_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Count tick selection
    // ------------------------------------------------------------
    // Tick marks the last cycle before the selected tap wraps
    wire s_tick = low_ones(s_cnt_r,
                           s_shift(mode_r.in_sel));
    wire w_tick = w_step && low_ones({5'h00, w_cnt_r},
                           w_shift(mode_r.in_sel[1:0]));
    // Time-base ticks are dropped while the hold is on
    wire w_tick_ok = w_tick && !tb_hold;
    // Prescalers run on, so a new tap may start mid-period
    wire tick      = tb_mode ? w_tick_ok : s_tick;

    // ------------------------------------------------------------
    // Up-counter
    // ------------------------------------------------------------
    // Overflow only from a real tick, never from a clear
    wire at_top   = (cnt_r == {CNT_W{1'b1}});
    wire overflow = tick && at_top && !wr_clear;

    // A clear beats a tick in the same cycle
    assign cnt_nxt = clr_cnt ? '0 :
                     tick ? cnt_r + 1'b1 : cnt_r;

    // Counter wraps naturally from all ones to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= `ITT_COUNT_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    // Reset value selects interval mode at the slowest tap
    // Every field is writable; the reserved bit is forced
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= itt_mode_t'(`ITT_MODE_RST);
        end else if (wr_mode) begin
            mode_r      <= wmode;
            mode_r.rsvd <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and control
    // ------------------------------------------------------------
    // Write one clears; a same-cycle overflow still sets
    always_comb begin
        status_nxt = status_r;
        if (wr_status) begin
            status_nxt = status_r & ~req.wdata;
        end
        if (overflow) begin
            status_nxt[`ITT_OVF_BIT] = 1'b1;
        end
    end

    // Unused status bits stay zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_r <= `ITT_STATUS_RST;
        end else begin
            status_r <= status_nxt & 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------
    // Only bit 0 is kept; other bits read back zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_r <= `ITT_MASK_RST;
        end else if (wr_mask) begin
            mask_r <= req.wdata & 8'h01;
        end
    end

    // Clock-out enable stands in for the port mode bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= `ITT_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= req.wdata & 8'h01;
        end
    end

    // Level interrupt, only while the enable bit is set
    wire [7:0] irq_src = status_r & mask_r;
    assign irq = |irq_src;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Counter reads zero in subactive: no bus sync there
    wire [7:0] cnt_view = subactive ? 8'h00 : cnt_r;
    // Reserved bit forced at the read too
    wire [7:0] mode_view = {mode_r.out_sel, 1'b1,
                            mode_r.timebase_mode_bit,
                            mode_r.in_sel};

    // Unmapped offsets and idle cycles read zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                `ITT_ADDR_MODE:   rdata_nxt = mode_view;
                `ITT_ADDR_COUNT:  rdata_nxt = cnt_view;
                `ITT_ADDR_STATUS: rdata_nxt = status_r;
                `ITT_ADDR_MASK:   rdata_nxt = mask_r;
                `ITT_ADDR_CTRL:   rdata_nxt = ctrl_r;
                default:          rdata_nxt = 8'h00;
            endcase
        end
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

    // ------------------------------------------------------------
    // Divided clock output
    // ------------------------------------------------------------
    // Bit n of a prescaler has period two to n plus one
    wire [3:0] s_taps = {s_cnt_r[1], s_cnt_r[2],
                         s_cnt_r[3], s_cnt_r[4]};
    wire [3:0] w_taps = {w_cnt_r[1], w_cnt_r[2],
                         w_cnt_r[3], w_cnt_r[4]};

    // System taps stop in subactive since that clock is off
    wire s_out = !subactive
                 && out_tap(s_taps, mode_r.out_sel[1:0]);
    wire w_out = out_tap(w_taps, mode_r.out_sel[1:0]);
    wire sel_out = mode_r.out_sel[2] ? w_out : s_out;

    assign clk_out_nxt = ctrl_r[`ITT_CLKOUT_EN_BIT]
                         && sel_out;

    // Registered so the pin has no decode glitches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_out_r <= 1'b0;
        end else begin
            clk_out_r <= clk_out_nxt;
        end
    end

    assign divided_clock_out = clk_out_r;

endmodule

// File: tb/itt_timer_chk.sv
// Port assertions for the interval and time-base timer
`timescale 1ns/1ps
`include "itt_consts.svh"

module itt_timer_chk
    import itt_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Watched ports
    input wire logic       sub_clk_in,
    input wire itt_pmode_t power_mode,
    input wire itt_req_t   req,
    input wire logic [7:0] rdata,
    input wire logic       divided_clock_out,
    input wire logic       irq
);
    logic [7:0] mode_r;
    logic       mask_r;
    logic       ctrl_r;

    // Decodes of the register port
    wire rd_mode = req.rd && req.addr == `ITT_ADDR_MODE;
    wire rd_cnt  = req.rd && req.addr == `ITT_ADDR_COUNT;
    wire wr_mode = req.wr && req.addr == `ITT_ADDR_MODE;
    wire wr_stat = req.wr && req.addr == `ITT_ADDR_STATUS && req.wdata[0];
    wire hold    = mode_r[3] && mode_r[2];

    // Shadows of what software wrote, since the checker cannot see inside
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= `ITT_MODE_RST;
            mask_r <= 1'b0;
            ctrl_r <= 1'b0;
        end else if (req.wr) begin
            if (wr_mode)
                mode_r <= req.wdata;
            if (req.addr == `ITT_ADDR_MASK)
                mask_r <= req.wdata[0];
            if (req.addr == `ITT_ADDR_CTRL)
                ctrl_r <= req.wdata[0];
        end
    end

    // ----
    // Assertions
    // ----
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_clear_wr;
        wr_mode && req.wdata[3:2] == 2'b11;
    endsequence
    sequence s_cnt_rd;
        rd_cnt;
    endsequence

    AST_RDATA_IDLE: assert property (!req.rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_MODE_RSVD: assert property (rd_mode |=> rdata[4])
        else $error("reserved mode bit read as zero");
    AST_MODE_ECHO: assert property (rd_mode |=> {rdata[7:5], rdata[3:0]} == {mode_r[7:5], mode_r[3:0]})
        else $error("mode read differs from written");
    AST_SUB_CNT: assert property (rd_cnt && power_mode == ITT_SUBACTIVE |=> rdata == 8'h00)
        else $error("counter readable in subactive");
    AST_HOLD_CNT: assert property (hold && rd_cnt |=> rdata == 8'h00)
        else $error("counter not held at zero");
    AST_CLEAR_SEQ: assert property (s_clear_wr ##1 s_cnt_rd |=> rdata == 8'h00)
        else $error("counter not cleared by mode write");
    AST_IRQ_MASK: assert property (!mask_r |-> !irq)
        else $error("interrupt while overflow masked");
    AST_IRQ_CLR: assert property (hold && $past(hold) && wr_stat |=> !irq)
        else $error("interrupt stays after flag clear");
    AST_OUT_OFF: assert property (!ctrl_r && !$past(ctrl_r) |-> !divided_clock_out)
        else $error("clock out while disabled");
    AST_SUB_TAP: assert property (power_mode == ITT_SUBACTIVE && $past(power_mode) == ITT_SUBACTIVE
        && !mode_r[7] && !$past(mode_r[7]) |-> !divided_clock_out)
        else $error("system tap out in subactive");
endmodule

// File: tb/tb.sv
// Self-checking bench for the interval and time-base timer
`timescale 1ns/1ps
`include "itt_consts.svh"

module tb
    import itt_pkg::*;
;
    logic       clk        = 1'b0;
    logic       rst        = 1'b1;
    logic       sub_clk_in = 1'b0;
    itt_pmode_t power_mode = ITT_ACTIVE;
    itt_req_t   req        = '0;
    logic [7:0] rdata;
    logic       divided_clock_out;
    logic       irq;
    logic [7:0] exp_q[$];
    logic [7:0] msk_q[$];
    logic [7:0] last_rd;
    logic       rd_seen    = 1'b0;
    int         err_total  = 0;
    int         checked    = 0;
    int         cyc        = 0;
    int         m;
    int         sh[8]      = '{13, 12, 11, 9, 8, 7, 5, 3};

    // Clocks: subclock sped up; its edges never meet a rising clk edge
    always #5 clk = ~clk;
    always #21.008 sub_clk_in = ~sub_clk_in;

    itt_timer itt_timer_inst (
        .clk               (clk),
        .rst               (rst),
        .sub_clk_in        (sub_clk_in),
        .power_mode        (power_mode),
        .req               (req),
        .rdata             (rdata),
        .divided_clock_out (divided_clock_out),
        .irq               (irq)
    );

    // ----
    // Tasks
    // ----
    task automatic ck(input logic [7:0] g, input logic [7:0] x, input logic [7:0] k);
        checked++;
        if ((g & k) !== (x & k)) begin
            err_total++;
            $display("MISMATCH %0t got %h want %h", $time, g, x);
        end
    endtask

    // Every access sets one strobe and clears the other, so no signal is assigned twice a step
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        req <= '{a, d, w, !w};
        @(posedge clk);
    endtask

    task automatic idle(input int n);
        req <= '0;
        repeat (n) @(posedge clk);
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] x, input logic [7:0] k);
        exp_q.push_back(x);
        msk_q.push_back(k);
        acc(1'b0, a, 8'h00);
    endtask

    // Counts rising edges of the clock pin over a window
    task automatic rises(input int n, input int x, input int t);
        int   c;
        logic p;
        c = 0;
        idle(4);
        p = divided_clock_out;
        repeat (n) begin
            @(posedge clk);
            if (divided_clock_out === 1'b1 && p === 1'b0)
                c++;
            p = divided_clock_out;
        end
        checked++;
        if (c < x - t || c > x + t) begin
            err_total++;
            $display("MISMATCH %0t rises %0d want %0d", $time, c, x);
        end
    endtask

    task automatic close_out();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Read monitor and hang guard
    always @(posedge clk) begin
        cyc++;
        if (rd_seen) begin
            last_rd = rdata;
            ck(rdata, exp_q.pop_front(), msk_q.pop_front());
        end
        rd_seen <= req.rd;
        if (cyc == 90000) begin
            err_total++;
            close_out();
        end
    end

    // ----
    // Main sequence
    // ----
    initial begin
        void'($urandom(32'h666b));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(`ITT_ADDR_MODE, 8'h10, 8'hff);
        rd_chk(`ITT_ADDR_COUNT, 8'h00, 8'hff);
        // A window of m tap periods must add exactly m counts
        for (int i = 0; i < 8; i++) begin
            m = 1 + $urandom % 2;
            acc(1'b1, `ITT_ADDR_MODE, 8'(i));
            idle(2);
            rd_chk(`ITT_ADDR_COUNT, 8'h00, 8'h00);
            idle((m << sh[i]) - 1);
            rd_chk(`ITT_ADDR_COUNT, last_rd + 8'(m), 8'hff);
        end
        acc(1'b1, `ITT_ADDR_MASK, 8'h00);
        acc(1'b1, `ITT_ADDR_STATUS, 8'h01);
        idle(2100);
        rd_chk(`ITT_ADDR_STATUS, 8'h01, 8'h01);
        ck({7'h00, irq}, 8'h00, 8'hff);
        acc(1'b1, `ITT_ADDR_MASK, 8'h01);
        idle(1);
        ck({7'h00, irq}, 8'h01, 8'hff);
        acc(1'b1, `ITT_ADDR_MODE, 8'h0c);
        rd_chk(`ITT_ADDR_COUNT, 8'h00, 8'hff);
        acc(1'b1, `ITT_ADDR_COUNT, 8'($urandom));
        rd_chk(`ITT_ADDR_COUNT, 8'h00, 8'hff);
        rd_chk(3'h5, 8'h00, 8'hff);
        rd_chk(`ITT_ADDR_MODE, 8'h1c, 8'hff);
        idle(3);
        acc(1'b1, `ITT_ADDR_STATUS, 8'h01);
        idle(1);
        ck({7'h00, irq}, 8'h00, 8'hff);
        rd_chk(`ITT_ADDR_STATUS, 8'h00, 8'h01);
        // Time base, shortest period: one count per four subclock edges
        acc(1'b1, `ITT_ADDR_MODE, 8'h0b);
        idle(1);
        m = 1 + $urandom % 3;
        repeat (4 * m + 2) @(posedge sub_clk_in);
        @(posedge clk);
        rd_chk(`ITT_ADDR_COUNT, 8'(m), 8'hff);
        acc(1'b1, `ITT_ADDR_CTRL, 8'h00);
        acc(1'b1, `ITT_ADDR_MODE, 8'h60);
        rises(64, 0, 0);
        acc(1'b1, `ITT_ADDR_CTRL, 8'h01);
        for (int c = 0; c < 8; c++) begin
            acc(1'b1, `ITT_ADDR_MODE, 8'(c << 5));
            if (c < 4)
                rises(64, 2 << c, 1);
            else
                rises(672, 5 << (c - 4), 1);
        end
        power_mode <= ITT_SUBACTIVE;
        acc(1'b1, `ITT_ADDR_MODE, 8'h60);
        rises(64, 0, 0);
        acc(1'b1, `ITT_ADDR_MODE, 8'he0);
        rises(672, 40, 1);
        rd_chk(`ITT_ADDR_COUNT, 8'h00, 8'hff);
        idle(2);
        close_out();
    end
endmodule

bind itt_timer itt_timer_chk itt_timer_chk_inst (
    .clk               (clk),
    .rst               (rst),
    .sub_clk_in        (sub_clk_in),
    .power_mode        (power_mode),
    .req               (req),
    .rdata             (rdata),
    .divided_clock_out (divided_clock_out),
    .irq               (irq)
);
